// [hw/fbm_pkg.sv]
// Constants, types and register map of the fieldbus master state control
package fbm_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TENTH_MS_NS = 100000;
  localparam int unsigned TICK_CYCLES = TENTH_MS_NS / CLK_PERIOD_NS;
  localparam int unsigned CYC_MIN_MS = 2;
  localparam logic [15:0] CYC_MIN_TENTHS = 16'(CYC_MIN_MS * 10);
  localparam int unsigned AVG_SHIFT = 3;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] ADR_CMD = 4'h0;
  localparam logic [3:0] ADR_STATE = 4'h1;
  localparam logic [3:0] ADR_BUS = 4'h2;
  localparam logic [3:0] ADR_ERRCNT = 4'h3;
  localparam logic [3:0] ADR_STN = 4'h4;
  localparam logic [3:0] ADR_MSI = 4'h5;
  localparam logic [3:0] ADR_TTR = 4'h6;
  localparam logic [3:0] ADR_CYCSET = 4'h7;
  localparam logic [3:0] ADR_LAST = 4'h8;
  localparam logic [3:0] ADR_MIN = 4'h9;
  localparam logic [3:0] ADR_AVG = 4'hA;
  localparam logic [3:0] ADR_MAX = 4'hB;

  // Command register fields
  localparam int unsigned CMD_STATE_LSB = 0;
  localparam int unsigned CMD_GO_BIT = 2;
  localparam int unsigned CMD_STATS_BIT = 4;

  // ----------------------------------------------------------------
  // Codes and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] STN_ADDR_MAX = 8'h7D;
  localparam logic [7:0] STATE_UNDEF = 8'h64;
  localparam logic [2:0] BS_OK = 3'h0;
  localparam logic [2:0] BS_ADDR = 3'h1;
  localparam logic [2:0] BS_BUS = 3'h2;
  localparam logic [2:0] BS_PROTO = 3'h3;
  localparam logic [2:0] BS_HW = 3'h4;
  localparam logic [2:0] BS_UNKNOWN = 3'h5;
  localparam logic [2:0] BS_CTRL_RST = 3'h6;
  localparam logic [7:0] RST_STN = 8'h00;
  localparam logic [15:0] RST_MSI = 16'h0010;
  localparam logic [15:0] RST_TTR = 16'h0064;
  localparam logic [15:0] RST_CYC = 16'h0014;

  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_STOP = 2'b01,
    ST_CLEAR = 2'b10,
    ST_OPER = 2'b11
  } fbm_state_type;

  typedef struct packed {
    logic dup_addr;
    logic bus_fault;
    logic frame_err;
    logic hw_fault;
    logic unknown_chg;
    logic ctrl_undef;
  } fbm_err_type;

  typedef struct packed {
    logic token_en;
    logic data_en;
    logic out_zero;
    logic failsafe;
    logic in_init;
  } fbm_mode_type;

endpackage

// [hw/fbm_ctrl.sv]
// Fieldbus master state control, bus status and cycle statistics
//
// Overview of operation
// - Switched off: no actions, no bus activity at all.
// - Stop: token passing continues, no data telegrams to slaves.
// - Clear: data exchange continues, every output byte sent is zero.
// - Clear: failsafe slaves get failsafe telegrams without payload.
// - Clear: slave inputs discarded, configured initial values used.
// - Operate: cyclic input and output exchange with all slaves.
// - Reset-statistics clears last, min, average and max to zero.
// - State code: 0 off, 1 stop, 2 clear, 3 operate, 100 undefined.
// - Undefined code reported while firmware update is running.
// - Bus code 0 healthy, 1 when own address used elsewhere.
// - Bus code 2 on bus malfunction.
// - Bus code 3 on bad frame, 4 on protocol hardware fault.
// - Bus code 5 on state change for unknown reason.
// - Undefined controller is reset and bus code becomes 6.
// - Nonzero bus code holds until the error has gone.
// - Running bus error count, readable.
// - Own station address configurable from 0 to 125.
// - Slave interval and token rotation time held in 0.1 ms units.
// - Bus cycle time configurable down to 2 ms.
// - Each cycle measured; last, min, average, max reported in 0.1 ms units.
// - Off after reset; host run makes master go to operate.
// - Host stop gives clear, unless already stop or off.
//
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/1ps

module fbm_ctrl #(
  parameter int unsigned TICK_CYCLES = fbm_pkg::TICK_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  input wire logic i_host_run,
  input wire logic i_fw_update,
  input wire fbm_pkg::fbm_err_type i_err,
  input wire logic i_cycle_done,
  input wire logic [7:0] i_out_byte,
  input wire logic [7:0] i_in_byte,
  input wire logic [7:0] i_init_byte,
  output logic [7:0] o_out_byte,
  output logic [7:0] o_in_byte,
  output fbm_pkg::fbm_mode_type o_mode,
  output logic o_cycle_start,
  output logic o_ctrl_reset,
  output logic [7:0] o_state_code,
  output logic [2:0] o_bus_state,
  output logic [7:0] o_stn_addr
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  fbm_pkg::fbm_state_type state_reg;
  fbm_pkg::fbm_state_type pend_reg;
  fbm_pkg::fbm_state_type pend_next;
  logic pend_set;
  logic run_prev_reg;
  logic [31:0] tick_cnt_reg;
  logic tick_reg;
  logic [15:0] cyc_cnt_reg;
  logic bound_reg;
  logic [15:0] cyc_set_reg;
  logic [15:0] msi_reg;
  logic [15:0] ttr_reg;
  logic [7:0] stn_reg;
  logic [15:0] meas_reg;
  logic [15:0] last_reg;
  logic [15:0] min_reg;
  logic [15:0] max_reg;
  logic [15:0] avg_reg;
  logic [15:0] avg_next;
  logic [15:0] errcnt_reg;
  logic err_prev_reg;
  logic undef_prev_reg;
  logic any_err;
  logic [2:0] bus_next;
  logic stats_clr;
  logic [15:0] rdata_next;

  assign any_err = |i_err;
  assign stats_clr = i_wr && (i_addr == fbm_pkg::ADR_CMD) &&
                     i_wdata[fbm_pkg::CMD_STATS_BIT];

  // ----------------------------------------------------------------
  // Tenth of a millisecond tick and bus cycle timer
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      tick_cnt_reg <= 32'h00000000;
      tick_reg <= 1'b0;
    end else if (tick_cnt_reg == 32'(TICK_CYCLES - 1)) begin
      tick_cnt_reg <= 32'h00000000;
      tick_reg <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
      tick_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cyc_cnt_reg <= 16'h0000;
      bound_reg <= 1'b0;
    end else if (tick_reg && (cyc_cnt_reg >= cyc_set_reg - 16'h0001)) begin
      cyc_cnt_reg <= 16'h0000;
      bound_reg <= 1'b1;
    end else begin
      if (tick_reg) begin
        cyc_cnt_reg <= cyc_cnt_reg + 16'h0001;
      end
      bound_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Pending state request
  // ----------------------------------------------------------------
  always_comb begin
    pend_next = pend_reg;
    pend_set = 1'b0;
    if (i_host_run && !run_prev_reg) begin
      pend_next = fbm_pkg::ST_OPER;
      pend_set = 1'b1;
    end else if (!i_host_run && run_prev_reg) begin
      if (state_reg == fbm_pkg::ST_OFF || state_reg == fbm_pkg::ST_STOP) begin
        pend_next = state_reg;
      end else begin
        pend_next = fbm_pkg::ST_CLEAR;
      end
      pend_set = 1'b1;
    end
    if (i_wr && (i_addr == fbm_pkg::ADR_CMD) &&
        i_wdata[fbm_pkg::CMD_GO_BIT]) begin
      pend_next = fbm_pkg::fbm_state_type'(
        i_wdata[fbm_pkg::CMD_STATE_LSB +: 2]);
      pend_set = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      run_prev_reg <= 1'b0;
      pend_reg <= fbm_pkg::ST_OFF;
    end else begin
      run_prev_reg <= i_host_run;
      if (pend_set) begin
        pend_reg <= pend_next;
      end
    end
  end

  // ----------------------------------------------------------------
  // Master state
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_reg <= fbm_pkg::ST_OFF;
    end else if (bound_reg) begin
      state_reg <= pend_reg;
    end
  end

  // state code with undefined during update
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_state_code <= 8'h00;
    end else if (i_fw_update) begin
      o_state_code <= fbm_pkg::STATE_UNDEF;
    end else begin
      o_state_code <= {6'h00, state_reg};
    end
  end

  // ----------------------------------------------------------------
  // Bus mode and data path
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_mode <= '0;
      o_cycle_start <= 1'b0;
    end else begin
      unique case (state_reg)
        fbm_pkg::ST_OFF: begin
          o_mode <= '0;
        end
        fbm_pkg::ST_STOP: begin
          o_mode <= '{token_en: 1'b1, default: 1'b0};
        end
        fbm_pkg::ST_CLEAR: begin
          o_mode <= '{token_en: 1'b1, data_en: 1'b1, out_zero: 1'b1,
                      failsafe: 1'b1, in_init: 1'b1};
        end
        fbm_pkg::ST_OPER: begin
          o_mode <= '{token_en: 1'b1, data_en: 1'b1, default: 1'b0};
        end
      endcase
      o_cycle_start <= bound_reg && (state_reg != fbm_pkg::ST_OFF);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_out_byte <= 8'h00;
    end else if (state_reg == fbm_pkg::ST_OPER) begin
      o_out_byte <= i_out_byte;
    end else begin
      o_out_byte <= 8'h00;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_in_byte <= 8'h00;
    end else if (state_reg == fbm_pkg::ST_OPER) begin
      o_in_byte <= i_in_byte;
    end else begin
      o_in_byte <= i_init_byte;
    end
  end

  // ----------------------------------------------------------------
  // Bus state and error count
  // ----------------------------------------------------------------
  always_comb begin
    bus_next = fbm_pkg::BS_OK;
    if (i_err.ctrl_undef) begin
      bus_next = fbm_pkg::BS_CTRL_RST;
    end else if (i_err.bus_fault) begin
      bus_next = fbm_pkg::BS_BUS;
    end else if (i_err.hw_fault) begin
      bus_next = fbm_pkg::BS_HW;
    end else if (i_err.frame_err) begin
      bus_next = fbm_pkg::BS_PROTO;
    end else if (i_err.dup_addr) begin
      bus_next = fbm_pkg::BS_ADDR;
    end else if (i_err.unknown_chg) begin
      bus_next = fbm_pkg::BS_UNKNOWN;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_bus_state <= fbm_pkg::BS_OK;
    end else begin
      o_bus_state <= bus_next;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      undef_prev_reg <= 1'b0;
      o_ctrl_reset <= 1'b0;
    end else begin
      undef_prev_reg <= i_err.ctrl_undef;
      o_ctrl_reset <= i_err.ctrl_undef && !undef_prev_reg;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      err_prev_reg <= 1'b0;
      errcnt_reg <= 16'h0000;
    end else begin
      err_prev_reg <= any_err;
      if (any_err && !err_prev_reg && errcnt_reg != 16'hFFFF) begin
        errcnt_reg <= errcnt_reg + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      stn_reg <= fbm_pkg::RST_STN;
    end else if (i_wr && i_addr == fbm_pkg::ADR_STN &&
                 i_wdata[7:0] <= fbm_pkg::STN_ADDR_MAX) begin
      stn_reg <= i_wdata[7:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      msi_reg <= fbm_pkg::RST_MSI;
      ttr_reg <= fbm_pkg::RST_TTR;
    end else if (i_wr) begin
      if (i_addr == fbm_pkg::ADR_MSI) begin
        msi_reg <= i_wdata;
      end
      if (i_addr == fbm_pkg::ADR_TTR) begin
        ttr_reg <= i_wdata;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cyc_set_reg <= fbm_pkg::RST_CYC;
    end else if (i_wr && i_addr == fbm_pkg::ADR_CYCSET) begin
      if (i_wdata < fbm_pkg::CYC_MIN_TENTHS) begin
        cyc_set_reg <= fbm_pkg::CYC_MIN_TENTHS;
      end else begin
        cyc_set_reg <= i_wdata;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_stn_addr <= fbm_pkg::RST_STN;
    end else begin
      o_stn_addr <= stn_reg;
    end
  end

  // ----------------------------------------------------------------
  // Cycle time statistics
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      meas_reg <= 16'h0000;
    end else if (i_cycle_done) begin
      // A tick in the closing cycle already counts for the next one
      meas_reg <= {15'h0000, tick_reg};
    end else if (tick_reg && meas_reg != 16'hFFFF) begin
      meas_reg <= meas_reg + 16'h0001;
    end
  end

  always_comb begin
    if (avg_reg == 16'h0000) begin
      avg_next = meas_reg;
    end else begin
      avg_next = 16'((19'(avg_reg) * 19'h00007 + 19'(meas_reg))
                     >> fbm_pkg::AVG_SHIFT);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n || stats_clr) begin
      last_reg <= 16'h0000;
      min_reg <= 16'h0000;
      max_reg <= 16'h0000;
      avg_reg <= 16'h0000;
    end else if (i_cycle_done) begin
      last_reg <= meas_reg;
      avg_reg <= avg_next;
      if (min_reg == 16'h0000 || meas_reg < min_reg) begin
        min_reg <= meas_reg;
      end
      if (meas_reg > max_reg) begin
        max_reg <= meas_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  always_comb begin
    rdata_next = 16'h0000;
    unique case (i_addr)
      fbm_pkg::ADR_STATE: rdata_next = {8'h00, o_state_code};
      fbm_pkg::ADR_BUS: rdata_next = {13'h0000, o_bus_state};
      fbm_pkg::ADR_ERRCNT: rdata_next = errcnt_reg;
      fbm_pkg::ADR_STN: rdata_next = {8'h00, stn_reg};
      fbm_pkg::ADR_MSI: rdata_next = msi_reg;
      fbm_pkg::ADR_TTR: rdata_next = ttr_reg;
      fbm_pkg::ADR_CYCSET: rdata_next = cyc_set_reg;
      fbm_pkg::ADR_LAST: rdata_next = last_reg;
      fbm_pkg::ADR_MIN: rdata_next = min_reg;
      fbm_pkg::ADR_AVG: rdata_next = avg_reg;
      fbm_pkg::ADR_MAX: rdata_next = max_reg;
      default: rdata_next = 16'h0000;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rdata <= 16'h0000;
    end else if (i_rd) begin
      o_rdata <= rdata_next;
    end else begin
      o_rdata <= 16'h0000;
    end
  end

endmodule

// [bench/fbm_ctrl_checker.sv]
// Assertion checker for the fieldbus master state control
`timescale 1ns/1ps

module fbm_ctrl_checker #(
  parameter int unsigned TICK_CYCLES = 4
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_fw_update,
  input wire fbm_pkg::fbm_err_type i_err,
  input wire logic [7:0] i_out_byte,
  input wire logic [7:0] i_in_byte,
  input wire logic [7:0] i_init_byte,
  input wire logic [7:0] o_out_byte,
  input wire logic [7:0] o_in_byte,
  input wire fbm_pkg::fbm_mode_type o_mode,
  input wire logic o_cycle_start,
  input wire logic o_ctrl_reset,
  input wire logic [7:0] o_state_code,
  input wire logic [2:0] o_bus_state
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  // ----------------------------------------------------------------
  // Expected bus code from the error levels, by priority
  // ----------------------------------------------------------------
  logic [2:0] bs_exp;
  always_comb begin
    if (i_err.ctrl_undef) bs_exp = fbm_pkg::BS_CTRL_RST;
    else if (i_err.bus_fault) bs_exp = fbm_pkg::BS_BUS;
    else if (i_err.hw_fault) bs_exp = fbm_pkg::BS_HW;
    else if (i_err.frame_err) bs_exp = fbm_pkg::BS_PROTO;
    else if (i_err.dup_addr) bs_exp = fbm_pkg::BS_ADDR;
    else if (i_err.unknown_chg) bs_exp = fbm_pkg::BS_UNKNOWN;
    else bs_exp = fbm_pkg::BS_OK;
  end

  state_undef_a: assert property (
    i_fw_update |=> o_state_code == fbm_pkg::STATE_UNDEF)
    else $error("state code not undefined during update");
  state_enc_a: assert property (
    o_mode == 5'h18 && !$past(i_fw_update) |-> o_state_code == 8'h03)
    else $error("operate state code wrong");
  mode_legal_a: assert property (
    o_mode inside {5'h00, 5'h10, 5'h1F, 5'h18})
    else $error("illegal mode pattern");
  off_silent_a: assert property (
    o_mode == 5'h00 && $past(o_mode) == 5'h00
      |-> !o_cycle_start && o_out_byte == 8'h00)
    else $error("activity while switched off");
  stop_nodata_a: assert property (
    o_mode == 5'h10 && $stable(o_mode) |-> o_out_byte == 8'h00)
    else $error("data sent in stop");
  clear_data_a: assert property (
    o_mode == 5'h1F && $stable(o_mode)
      |-> o_out_byte == 8'h00 && o_in_byte == $past(i_init_byte))
    else $error("clear data path wrong");
  oper_data_a: assert property (
    o_mode == 5'h18 && $stable(o_mode) |-> o_out_byte == $past(i_out_byte)
      && o_in_byte == $past(i_in_byte))
    else $error("operate data path wrong");
  bus_code_a: assert property (
    1'b1 |=> o_bus_state == $past(bs_exp))
    else $error("bus code wrong");
  ctrl_rst_a: assert property (
    $rose(i_err.ctrl_undef) |=> o_ctrl_reset ##1 !o_ctrl_reset)
    else $error("controller reset pulse wrong");
endmodule

bind fbm_ctrl fbm_ctrl_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_fw_update(i_fw_update),
  .i_err(i_err), .i_out_byte(i_out_byte), .i_in_byte(i_in_byte),
  .i_init_byte(i_init_byte), .o_out_byte(o_out_byte),
  .o_in_byte(o_in_byte), .o_mode(o_mode), .o_cycle_start(o_cycle_start),
  .o_ctrl_reset(o_ctrl_reset), .o_state_code(o_state_code),
  .o_bus_state(o_bus_state)
);

// [bench/fbm_slaves.sv]
// Behavioural model of the slave stations on the bus side
`timescale 1ns/1ps

module fbm_slaves (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_cycle_start,
  input wire logic [7:0] i_delay,
  output logic o_cycle_done,
  output logic [7:0] o_in_byte
);
  logic [7:0] cnt_reg;
  logic busy_reg;

  always_ff @(posedge i_clk) begin
    o_cycle_done <= 1'b0;
    if (!i_rst_n) begin
      busy_reg <= 1'b0;
      cnt_reg <= 8'h00;
    end else if (i_cycle_start) begin
      busy_reg <= 1'b1;
      cnt_reg <= 8'h00;
    end else if (busy_reg) begin
      cnt_reg <= cnt_reg + 8'h01;
      if (cnt_reg == i_delay) begin
        busy_reg <= 1'b0;
        o_cycle_done <= 1'b1;
      end
    end
  end

  // Input data changes every cycle and repeats only after 256 cycles, so a stale value cannot pass as fresh
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_in_byte <= 8'h5A;
    end else begin
      o_in_byte <= o_in_byte + 8'h3B;
    end
  end
endmodule

// [bench/tb_top.sv]
// Self-checking testbench of the fieldbus master state control
`timescale 1ns/1ps

`define CHK(got, exp) begin \
  n_checks++; \
  if ((got) !== (exp)) begin \
    miscompares++; \
    $display("mismatch t=%0t got %0h exp %0h", $time, got, exp); \
  end \
end

module tb_top;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [15:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_host_run = 1'b0;
  logic i_fw_update = 1'b0;
  fbm_pkg::fbm_err_type err_r = '0;
  logic [7:0] out_b = 8'h00;
  logic [7:0] init_b = 8'h00;
  logic [7:0] delay = 8'h01;
  logic done, cstart, o_ctrl_reset;
  logic [7:0] in_b, o_out_byte, o_in_byte, o_state_code, o_stn_addr;
  logic [15:0] o_rdata, rv, base;
  logic [2:0] o_bus_state;
  logic [5:0] e;
  logic [1:0] s;
  fbm_pkg::fbm_mode_type o_mode;
  int miscompares = 0;
  int n_checks = 0;
  int k;
  logic [3:0] ra [5] = '{fbm_pkg::ADR_STN, fbm_pkg::ADR_MSI,
    fbm_pkg::ADR_TTR, fbm_pkg::ADR_CYCSET, 4'hC};
  logic [15:0] rx [5] = '{16'(fbm_pkg::RST_STN), fbm_pkg::RST_MSI,
    fbm_pkg::RST_TTR, fbm_pkg::RST_CYC, 16'h0000};

  always #5 i_clk = ~i_clk;

  always @(posedge i_clk) begin
    out_b <= 8'($urandom);
    init_b <= 8'($urandom);
  end

  fbm_ctrl #(.TICK_CYCLES(4)) DUT (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_host_run(i_host_run),
    .i_fw_update(i_fw_update), .i_err(err_r), .i_cycle_done(done),
    .i_out_byte(out_b), .i_in_byte(in_b), .i_init_byte(init_b),
    .o_out_byte(o_out_byte), .o_in_byte(o_in_byte), .o_mode(o_mode),
    .o_cycle_start(cstart), .o_ctrl_reset(o_ctrl_reset),
    .o_state_code(o_state_code), .o_bus_state(o_bus_state),
    .o_stn_addr(o_stn_addr)
  );

  fbm_slaves SLV (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_cycle_start(cstart),
    .i_delay(delay), .o_cycle_done(done), .o_in_byte(in_b)
  );

  function automatic logic [4:0] exp_mode(input logic [1:0] st);
    case (st)
      2'h0: return 5'h00;
      2'h1: return 5'h10;
      2'h2: return 5'h1F;
      default: return 5'h18;
    endcase
  endfunction

  function automatic logic [2:0] exp_bs(input logic [5:0] ev);
    if (ev[0]) return fbm_pkg::BS_CTRL_RST;
    if (ev[4]) return fbm_pkg::BS_BUS;
    if (ev[2]) return fbm_pkg::BS_HW;
    if (ev[3]) return fbm_pkg::BS_PROTO;
    if (ev[5]) return fbm_pkg::BS_ADDR;
    if (ev[1]) return fbm_pkg::BS_UNKNOWN;
    return fbm_pkg::BS_OK;
  endfunction

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    rv = o_rdata;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic run(input logic v);
    @(posedge i_clk);
    i_host_run <= v;
  endtask

  task automatic wait_code(input logic [7:0] c);
    k = 0;
    while (o_state_code !== c && k < 300) begin
      cyc(1);
      k++;
    end
    `CHK(o_state_code, c)
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #300000;
    miscompares++;
    final_report();
  end

  initial begin
    void'($urandom(64));
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    cyc(1);
    `CHK(o_state_code, 8'h00)
    `CHK(o_mode, 5'h00)
    for (int i = 0; i < 5; i++) begin
      rd(ra[i]);
      `CHK(rv, rx[i])
    end
    wr(fbm_pkg::ADR_STN, 16'h007D);
    wr(fbm_pkg::ADR_STN, 16'h007E);
    rd(fbm_pkg::ADR_STN);
    `CHK(rv, 16'h007D)
    `CHK(o_stn_addr, 8'h7D)
    for (int i = 1; i < 3; i++) begin
      base = 16'($urandom);
      wr(ra[i], base);
      rd(ra[i]);
      `CHK(rv, base)
    end
    wr(fbm_pkg::ADR_CYCSET, 16'h0005);
    rd(fbm_pkg::ADR_CYCSET);
    `CHK(rv, 16'h0014)
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      s = 2'(i + 1);
      wr(fbm_pkg::ADR_CMD, 16'h0004 | 16'(s));
      wait_code(8'(s));
      `CHK(o_mode, exp_mode(s))
      rd(fbm_pkg::ADR_STATE);
      `CHK(rv, 16'(s))
    end
    @(posedge i_clk);
    i_fw_update <= 1'b1;
    cyc(2);
    `CHK(o_state_code, fbm_pkg::STATE_UNDEF)
    @(posedge i_clk);
    i_fw_update <= 1'b0;
    $display("test commands done");
    run(1'b1);
    wait_code(8'h03);
    wr(fbm_pkg::ADR_CMD, 16'h0005);
    wait_code(8'h01);
    run(1'b0);
    cyc(250);
    `CHK(o_state_code, 8'h01)
    run(1'b1);
    wait_code(8'h03);
    run(1'b0);
    wait_code(8'h02);
    $display("test host state done");
    @(posedge i_clk);
    delay <= 8'h3C;
    // Second end of cycle is sure to come from the long slave delay
    repeat (2) begin
      k = 0;
      while (done !== 1'b1 && k < 400) begin
        cyc(1);
        k++;
      end
      cyc(1);
    end
    wr(fbm_pkg::ADR_CMD, 16'h0010);
    for (int i = 8; i < 12; i++) begin
      rd(4'(i));
      `CHK(rv, 16'h0000)
    end
    cyc(300);
    rd(fbm_pkg::ADR_LAST);
    `CHK(rv, 16'h0014)
    rd(fbm_pkg::ADR_MAX);
    `CHK(rv, 16'h0014)
    wr(fbm_pkg::ADR_CYCSET, 16'h001E);
    cyc(400);
    rd(fbm_pkg::ADR_LAST);
    `CHK(rv, 16'h001E)
    rd(fbm_pkg::ADR_MAX);
    `CHK(rv, 16'h001E)
    rd(fbm_pkg::ADR_MIN);
    `CHK(rv > 16'h0000 && rv <= 16'h0014, 1'b1)
    rd(fbm_pkg::ADR_AVG);
    `CHK(rv >= 16'h0014 && rv <= 16'h001E, 1'b1)
    $display("test statistics done");
    rd(fbm_pkg::ADR_ERRCNT);
    base = rv;
    for (int i = 0; i < 12; i++) begin
      e = (i < 6) ? 6'(1 << i) : 6'($urandom_range(63, 1));
      @(posedge i_clk);
      err_r <= fbm_pkg::fbm_err_type'(e);
      cyc(4);
      `CHK(o_bus_state, exp_bs(e))
      @(posedge i_clk);
      err_r <= '0;
      cyc(2);
      `CHK(o_bus_state, fbm_pkg::BS_OK)
    end
    rd(fbm_pkg::ADR_ERRCNT);
    `CHK(rv, base + 16'h000C)
    $display("test bus errors done");
    final_report();
  end
endmodule
